// ===== core/bsc_dec_if.sv
// Purpose: Carries decoded instruction fields from the decoder to the execution control.
// Assumes: The decoder is purely combinational.
// Notes: One modport per side.
`timescale 1ns/1ps
interface bsc_dec_if;
	logic is_test_clear;
	logic is_test_set;
	logic is_call;
	logic [bsc_pkg::BIT_W-1:0] bit_idx;
	logic [bsc_pkg::ADDR_W-1:0] file_addr;
	logic [bsc_pkg::PC_W-1:0] call_target;
	logic [bsc_pkg::PC_W-1:0] return_addr;

	modport decoder (
		output is_test_clear,
		output is_test_set,
		output is_call,
		output bit_idx,
		output file_addr,
		output call_target,
		output return_addr
	);
	modport control (
		input is_test_clear,
		input is_test_set,
		input is_call,
		input bit_idx,
		input file_addr,
		input call_target,
		input return_addr
	);
endinterface : bsc_dec_if

// ===== core/bsc_decode.sv
// Purpose: Decodes the two bit tests and the call, and forms call addresses.
// Assumes: Word, program counter and latch are stable while the decode is used.
// Notes: Other opcodes decode to none of the three kinds.
`timescale 1ns/1ps
module bsc_decode (
	input wire logic [bsc_pkg::INSTR_W-1:0] instr_word,
	input wire logic [bsc_pkg::PC_W-1:0] pc,
	input wire logic [7:0] pc_high_latch,
	bsc_dec_if.decoder dec
);
	// Opcode matches; the call prefix is three bits, the tests four.
	assign dec.is_test_clear =
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::TEST_OP_LSB] == bsc_pkg::OP_TEST_CLEAR);
	assign dec.is_test_set =
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::TEST_OP_LSB] == bsc_pkg::OP_TEST_SET);
	assign dec.is_call =
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::CALL_OP_LSB] == bsc_pkg::OP_CALL);

	// Operand fields.
	assign dec.bit_idx = instr_word[bsc_pkg::BIT_LSB +: bsc_pkg::BIT_W];
	assign dec.file_addr = instr_word[bsc_pkg::ADDR_LSB +: bsc_pkg::ADDR_W];

	// Call target: latch bits above the immediate, so page selection is software's job.
	assign dec.call_target = {pc_high_latch[bsc_pkg::LATCH_HI_BIT:bsc_pkg::LATCH_LO_BIT],
		instr_word[bsc_pkg::IMM_LSB +: bsc_pkg::IMM_W]};
	assign dec.return_addr = pc + bsc_pkg::PC_STEP;
endmodule : bsc_decode

// ===== core/bsc_exec.sv
// Purpose: Executes the bit-test-and-skip instructions and the subroutine call.
// Assumes: All inputs come from core logic on sys_clk; file_data answers file_addr combinationally.
// Notes: One sys_clk cycle stands for one instruction cycle; all outputs are flip-flops.
`timescale 1ns/1ps
module bsc_exec (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic instr_valid,
	input wire logic [bsc_pkg::INSTR_W-1:0] instr_word,
	input wire logic [bsc_pkg::PC_W-1:0] pc,
	input wire logic [7:0] pc_high_latch,
	input wire logic [bsc_pkg::DATA_W-1:0] file_data,
	output logic instr_ready,
	output logic [bsc_pkg::ADDR_W-1:0] file_addr,
	output logic fetch_flush,
	output logic push_valid,
	output logic [bsc_pkg::PC_W-1:0] push_data,
	output logic pc_load,
	output logic [bsc_pkg::PC_W-1:0] pc_target,
	output logic exec_done
);
	bsc_dec_if dec ();

	bsc_decode u_decode (
		.instr_word(instr_word),
		.pc(pc),
		.pc_high_latch(pc_high_latch),
		.dec(dec.decoder)
	);

	bsc_pkg::bsc_state_t state;
	bsc_pkg::bsc_state_t next_state;
	logic op_clear;
	logic op_set;
	logic [bsc_pkg::BIT_W-1:0] bit_idx;

	// Acceptance and the skip decision. Other opcodes are not taken, so the core
	// routes them elsewhere and this unit stays idle.
	wire accept = instr_valid && instr_ready;
	wire take_test = accept && (dec.is_test_clear || dec.is_test_set);
	wire take_call = accept && dec.is_call;
	wire tested_bit = bsc_pkg::bsc_bit_of(file_data, bit_idx);
	wire skip_now = (state == bsc_pkg::BSC_TEST) &&
		((op_clear && !tested_bit) ||
		(op_set && tested_bit));
	wire last_cycle = ((state == bsc_pkg::BSC_TEST) && !skip_now) ||
		(state == bsc_pkg::BSC_NOP) || (state == bsc_pkg::BSC_CALL2);

	// Next state. A skip inserts one no-op cycle; a call always spends two cycles.
	always_comb begin
		case (state)
			bsc_pkg::BSC_IDLE: begin
				if (take_test) begin
					next_state = bsc_pkg::BSC_TEST;
				end else if (take_call) begin
					next_state = bsc_pkg::BSC_CALL1;
				end else begin
					next_state = bsc_pkg::BSC_IDLE;
				end
			end
			bsc_pkg::BSC_TEST: begin
				if (skip_now) begin
					next_state = bsc_pkg::BSC_NOP;
				end else begin
					next_state = bsc_pkg::BSC_IDLE;
				end
			end
			bsc_pkg::BSC_NOP: next_state = bsc_pkg::BSC_IDLE;
			bsc_pkg::BSC_CALL1: next_state = bsc_pkg::BSC_CALL2;
			bsc_pkg::BSC_CALL2: next_state = bsc_pkg::BSC_IDLE;
			default: next_state = bsc_pkg::BSC_IDLE;
		endcase
	end

	// State and ready; ready is registered so it follows the next state.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state <= bsc_pkg::BSC_IDLE;
			instr_ready <= 1'b1;
		end else begin
			state <= next_state;
			instr_ready <= (next_state == bsc_pkg::BSC_IDLE);
		end
	end

	// Latched operands of a bit test; the address is held for the whole test cycle.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			op_clear <= 1'b0;
			op_set <= 1'b0;
			bit_idx <= 3'h0;
			file_addr <= 7'h00;
		end else if (take_test) begin
			op_clear <= dec.is_test_clear;
			op_set <= dec.is_test_set;
			bit_idx <= dec.bit_idx;
			file_addr <= dec.file_addr;
		end
	end

	// Flush: during a skip's no-op cycle, or the first cycle of a call.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			fetch_flush <= 1'b0;
		end else begin
			fetch_flush <= skip_now || take_call;
		end
	end

	// Stack push and program counter load of a call, one cycle each. The push and
	// the load share a cycle; the stack takes the push before the new fetch uses pc.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			push_valid <= 1'b0;
			push_data <= 13'h0000;
			pc_load <= 1'b0;
			pc_target <= 13'h0000;
		end else begin
			push_valid <= take_call;
			pc_load <= take_call;
			if (take_call) begin
				push_data <= dec.return_addr;
				pc_target <= dec.call_target;
			end
		end
	end

	// Completion pulse, one cycle after the last execution cycle. No flag output
	// exists, so status flags cannot be touched by these instructions.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			exec_done <= 1'b0;
		end else begin
			exec_done <= last_cycle;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	a_clear_skip_taken: assert property (
		(state == bsc_pkg::BSC_TEST) && op_clear && !file_data[bit_idx]
		|=> fetch_flush && (state == bsc_pkg::BSC_NOP))
		else $error("clear test did not skip on a zero bit");

	a_set_skip_taken: assert property (
		(state == bsc_pkg::BSC_TEST) && op_set
		|=> (fetch_flush == $past(file_data[bit_idx])))
		else $error("set test skip does not follow the tested bit");

	// Ready is checked in the done cycle itself, since a new word may be taken
	// at the edge that ends it and would pull ready low again one cycle later.
	a_skip_two_cycles: assert property (
		(state == bsc_pkg::BSC_TEST) && skip_now
		|=> !exec_done && fetch_flush ##1 exec_done && !fetch_flush && instr_ready)
		else $error("skipping test did not take two cycles");

	// Call checks decode the opcode from the package fields, not from the decoder,
	// so a broken decoder cannot hide behind its own output.
	a_call_push_addr: assert property (
		instr_valid && instr_ready &&
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::CALL_OP_LSB] == bsc_pkg::OP_CALL)
		|=> push_valid && (push_data == $past(pc) + bsc_pkg::PC_STEP))
		else $error("call pushed a wrong return address");

	a_call_low_target: assert property (
		instr_valid && instr_ready &&
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::CALL_OP_LSB] == bsc_pkg::OP_CALL)
		|=> pc_load &&
		(pc_target[bsc_pkg::IMM_W-1:0] == $past(instr_word[bsc_pkg::IMM_W-1:0])))
		else $error("call loaded a wrong immediate");

	a_call_high_bits: assert property (
		pc_load |-> (pc_target[bsc_pkg::PC_W-1:bsc_pkg::IMM_W] ==
		$past(pc_high_latch[bsc_pkg::LATCH_HI_BIT:bsc_pkg::LATCH_LO_BIT])))
		else $error("call upper bits do not follow the latch");

	a_call_two_cycles: assert property (
		instr_valid && instr_ready &&
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::CALL_OP_LSB] == bsc_pkg::OP_CALL)
		|=> fetch_flush && !instr_ready ##1 !push_valid && !exec_done ##1 exec_done && instr_ready)
		else $error("call did not take exactly two cycles");

	a_test_one_cycle: assert property (
		(state == bsc_pkg::BSC_TEST) && !skip_now
		|=> exec_done && !fetch_flush && instr_ready && !push_valid && !pc_load)
		else $error("non-skipping test did not finish in one cycle");

	// A clear test on a set bit must fall through in one cycle with no flush.
	a_clear_no_skip: assert property (
		(state == bsc_pkg::BSC_TEST) && op_clear && file_data[bit_idx]
		|=> !fetch_flush && exec_done)
		else $error("clear test skipped on a one bit");

	// Pulses last one cycle; a second flush would throw away a word that should run.
	a_flush_one_pulse: assert property (
		fetch_flush |=> !fetch_flush)
		else $error("flush lasted more than one cycle");

	a_done_one_pulse: assert property (
		exec_done |=> !exec_done)
		else $error("done lasted more than one cycle");

	// While busy nothing is taken, so no second push or load can start.
	a_busy_no_call: assert property (
		!instr_ready |=> !push_valid && !pc_load)
		else $error("call started while the unit was busy");

	// Words of other instructions leave the unit idle and the fetch untouched.
	a_other_stays_idle: assert property (
		instr_valid && instr_ready &&
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::TEST_OP_LSB] != bsc_pkg::OP_TEST_CLEAR) &&
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::TEST_OP_LSB] != bsc_pkg::OP_TEST_SET) &&
		(instr_word[bsc_pkg::INSTR_W-1:bsc_pkg::CALL_OP_LSB] != bsc_pkg::OP_CALL)
		|=> instr_ready && !fetch_flush && !push_valid && !pc_load)
		else $error("an unrelated opcode was executed");

	// The tested address stays put unless a new word is taken.
	a_addr_held: assert property (
		!(instr_valid && instr_ready) |=> $stable(file_addr))
		else $error("tested address changed without a new word");

	// Leaving reset the unit is idle and ready, with every pulse low.
	a_idle_after_reset: assert property (
		$rose(reset_n) |-> instr_ready && !exec_done && !fetch_flush &&
		!push_valid && !pc_load)
		else $error("unit not idle when reset was released");
endmodule : bsc_exec

// ===== core/bsc_pkg.sv
// Purpose: Shared constants, state type and helpers for the bit-test and call execution unit.
// Assumes: 14-bit instruction words, 13-bit program counter, 8-bit file registers.
// Notes: All opcode fields and field positions are named here once.
// Notes on behaviour
// - Skip-if-clear test skips the next instruction when the addressed bit is zero.
// - Skip-if-set test skips the next instruction when the addressed bit is one.
// - A skipping test discards the prefetched word, runs a no-op, takes two cycles.
// - A call first pushes the current program counter plus one onto the stack.
// - A call loads its 11-bit immediate into program counter bits 10 to 0.
// - A call fills program counter bits 12 and 11 from latch bits 4 and 3.
// - A call is one word, always two cycles, and flushes the prefetched word.
package bsc_pkg;
	localparam int INSTR_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int BIT_W = 3;
	localparam int IMM_W = 11;
	// Opcode fields of the instruction word.
	localparam int TEST_OP_LSB = 10;
	localparam logic [3:0] OP_TEST_CLEAR = 4'h6;
	localparam logic [3:0] OP_TEST_SET = 4'h7;
	localparam int CALL_OP_LSB = 11;
	localparam logic [2:0] OP_CALL = 3'h4;
	// Operand positions.
	localparam int BIT_LSB = 7;
	localparam int ADDR_LSB = 0;
	localparam int IMM_LSB = 0;
	// Latch bits that supply the upper program counter bits on a call.
	localparam int LATCH_HI_BIT = 4;
	localparam int LATCH_LO_BIT = 3;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

	typedef enum logic [2:0] {
		BSC_IDLE = 3'b000,
		BSC_TEST = 3'b001,
		BSC_NOP = 3'b010,
		BSC_CALL1 = 3'b011,
		BSC_CALL2 = 3'b100
	} bsc_state_t;

	// Picks one bit of a file register value.
	function automatic logic bsc_bit_of(input logic [DATA_W-1:0] value,
		input logic [BIT_W-1:0] idx);
		bsc_bit_of = value[idx];
	endfunction : bsc_bit_of
endpackage : bsc_pkg

// ===== testbench/bsc_exec_tb.sv
// Purpose: Self-checking bench for the bit-test and call execution unit.
// Assumes: Timing as the unit's contract sets it; the register file is a fixed pattern.
// Notes: Each scenario issues instructions and judges pulse timing; the bit test and call scenarios also judge carried values.
`timescale 1ns/1ps
module testbench;
	logic sys_clk;
	logic reset_n;
	logic instr_valid;
	logic [bsc_pkg::INSTR_W-1:0] instr_word;
	logic [bsc_pkg::PC_W-1:0] pc;
	logic [7:0] pc_high_latch;
	logic [bsc_pkg::DATA_W-1:0] file_data;
	logic instr_ready;
	logic fetch_flush;
	logic push_valid;
	logic pc_load;
	logic exec_done;
	logic [bsc_pkg::ADDR_W-1:0] file_addr;
	logic [bsc_pkg::PC_W-1:0] push_data;
	logic [bsc_pkg::PC_W-1:0] pc_target;
	int n_fail;
	int n_tests;
	int n_cyc;
	logic [15:0] seen_at;
	logic [bsc_pkg::ADDR_W-1:0] seen_addr;
	logic [bsc_pkg::PC_W-1:0] seen_push;
	logic [bsc_pkg::PC_W-1:0] seen_target;
	logic seen_busy;

	bsc_exec i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
		.instr_word(instr_word), .pc(pc), .pc_high_latch(pc_high_latch),
		.file_data(file_data), .instr_ready(instr_ready), .file_addr(file_addr),
		.fetch_flush(fetch_flush), .push_valid(push_valid), .push_data(push_data),
		.pc_load(pc_load), .pc_target(pc_target), .exec_done(exec_done));

	// A fixed pattern lets the bench know every register bit without a memory model.
	assign file_data = {1'b0, file_addr} ^ 8'hA5;

	// Free-running clock, 5 ns period.
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// A hang is cut short well past the expected few hundred cycles.
	always @(posedge sys_clk) begin
		n_cyc++;
		if (n_cyc == 1000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Offers one word, then records in which cycle each pulse was seen (nibbles:
	// done, flush, push, load). Only the last occurrence is kept, which is enough here.
	task automatic issue(input logic [13:0] w, input logic [12:0] p, input logic [7:0] l);
		instr_valid = 1'b1;
		instr_word = w;
		pc = p;
		pc_high_latch = l;
		seen_at = 16'h0000;
		@(posedge sys_clk);
		#1;
		instr_valid = 1'b0;
		seen_addr = file_addr;
		seen_push = push_data;
		seen_target = pc_target;
		seen_busy = ~instr_ready;
		for (int n = 1; n <= 5; n++) begin
			if (exec_done === 1'b1) seen_at[15:12] = 4'(n);
			if (fetch_flush === 1'b1) seen_at[11:8] = 4'(n);
			if (push_valid === 1'b1) seen_at[7:4] = 4'(n);
			if (pc_load === 1'b1) seen_at[3:0] = 4'(n);
			@(posedge sys_clk);
			#1;
		end
	endtask : issue

	// Every bit index at both ends of the register address range.
	task automatic bit_run(input logic [3:0] op, input logic on_set);
		logic [2:0] b;
		logic [6:0] f;
		logic [7:0] d;
		for (int i = 0; i < 16; i++) begin
			b = 3'(i);
			f = (i < 8) ? 7'h00 : 7'h7F;
			d = {1'b0, f} ^ 8'hA5;
			issue({op, b, f}, 13'h0100, 8'h00);
			chk(16'(seen_addr), 16'(f));
			chk(seen_at, (d[b] == on_set) ? 16'h3200 : 16'h2000);
		end
	endtask : bit_run

	task automatic t_clear();
		bit_run(bsc_pkg::OP_TEST_CLEAR, 1'b0);
		$display("Test skip-when-clear finished.");
	endtask : t_clear

	task automatic t_set();
		bit_run(bsc_pkg::OP_TEST_SET, 1'b1);
		$display("Test skip-when-set finished.");
	endtask : t_set

	// Calls with a wrapping return address, with both latch bits set, and with latch bit 3 alone.
	task automatic t_call();
		issue({bsc_pkg::OP_CALL, 11'h7FF}, 13'h1FFF, 8'h18);
		chk(16'(seen_push), 16'h0000);
		chk(16'(seen_target), 16'h1FFF);
		chk(seen_at, 16'h3111);
		issue({bsc_pkg::OP_CALL, 11'h555}, 13'h0ABC, 8'hEF);
		chk(16'(seen_push), 16'h0ABD);
		chk(16'(seen_target), 16'h0D55);
		chk(16'(seen_busy), 16'h0001);
		$display("Test call finished.");
	endtask : t_call

	// Neighbouring bit set and clear opcodes must not be taken for tests.
	task automatic t_other();
		issue(14'h1000, 13'h0200, 8'h00);
		chk(seen_at, 16'h0000);
		chk(16'(seen_busy), 16'h0000);
		issue(14'h1400, 13'h0200, 8'h00);
		chk(seen_at, 16'h0000);
		$display("Test other opcodes finished.");
	endtask : t_other

	// Reset in the middle of a call: pulses drop, ready returns, and the next word runs.
	task automatic t_reset();
		instr_valid = 1'b1;
		instr_word = {bsc_pkg::OP_CALL, 11'h123};
		pc = 13'h0040;
		pc_high_latch = 8'h18;
		@(posedge sys_clk);
		#1;
		instr_valid = 1'b0;
		chk(16'(push_valid), 16'h0001);
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(16'({instr_ready, fetch_flush, push_valid, pc_load, exec_done}), 16'h0010);
		reset_n = 1'b1;
		issue({bsc_pkg::OP_TEST_SET, 3'h0, 7'h00}, 13'h0000, 8'h00);
		chk(seen_at, 16'h3200);
		$display("Test reset in mid-call finished.");
	endtask : t_reset

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d.", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Reset for four cycles, then the scenarios in turn.
	initial begin
		n_fail = 0;
		n_tests = 0;
		n_cyc = 0;
		reset_n = 1'b0;
		instr_valid = 1'b0;
		instr_word = 14'h0000;
		pc = 13'h0000;
		pc_high_latch = 8'h00;
		repeat (4) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		t_clear();
		t_set();
		t_call();
		t_other();
		t_reset();
		print_verdict();
	end
endmodule : testbench
